// ### spimsp_cfg.svh
`ifndef SPIMSP_CFG_SVH
`define SPIMSP_CFG_SVH
// ==========================================================
// register byte offsets
`define SPIMSP_OFF_CTRL 12'h000
`define SPIMSP_OFF_STAT 12'h004
`define SPIMSP_OFF_DATA 12'h008
// ==========================================================
// control field positions
`define SPIMSP_CTL_EN 7
`define SPIMSP_CTL_MST 6
`define SPIMSP_CTL_CPOL 5
`define SPIMSP_CTL_CPHA 4
`define SPIMSP_CTL_SELECT_DISABLE 3
`define SPIMSP_CTL_LSB 2
// ==========================================================
// status field positions
`define SPIMSP_ST_DONE 7
`define SPIMSP_ST_WCOL 6
`define SPIMSP_ST_MODE_FAULT_FLAG 5
`define SPIMSP_ST_OVR 4
`define SPIMSP_ST_FULL 3
`define SPIMSP_ST_BUSY 2
// ==========================================================
// reset values and counts
`define SPIMSP_CTRL_RST 8'h00
`define SPIMSP_BITS 4'h8
`endif

// ### spimsp_clkdiv.sv
`timescale 1ns/10ps
`include "spimsp_cfg.svh"
module spimsp_clkdiv import spimsp_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic run,
	input wire logic [1:0] rate,
	output logic tick
);
	// ==========================================================
	// half period tick: sysclk/2 gives a tick every cycle
	logic [2:0] cnt_q;
	logic [2:0] lim;
	always_comb begin
		lim = 3'((4'h1 << rate) - 4'h1);
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt_q <= 3'h0;
		end else if (ce) begin
			if (!run || tick) begin
				cnt_q <= 3'h0;
			end else begin
				cnt_q <= cnt_q + 3'h1;
			end
		end
	end
	assign tick = run && (cnt_q == lim);
endmodule // spimsp_clkdiv

// ### spimsp_far_slave.sv
`timescale 1ns/10ps
module spimsp_far_slave (
	input wire logic sck,
	input wire logic mosi,
	input wire logic sel_n,
	input wire logic [7:0] tx,
	output logic miso,
	output logic [7:0] rx
);
	// ==========
	// far slave, sample on rising, shift on falling
	logic [7:0] sh_q;
	always @(negedge sel_n) sh_q = tx;
	always @(posedge sck) if (!sel_n) rx = {rx[6:0], mosi};
	always @(negedge sck) if (!sel_n) sh_q = {sh_q[6:0], 1'b0};
	// released line shows the inverse of the shifter's top bit
	assign miso = sel_n ? ~sh_q[7] : sh_q[7];
endmodule // spimsp_far_slave

// ### spimsp_pkg.sv
package spimsp_pkg;
	typedef enum logic [1:0] {
		SPIMSP_IDLE = 2'b00,
		SPIMSP_LEAD = 2'b01,
		SPIMSP_TRAIL = 2'b10
	} spimsp_state_e;
	typedef struct packed {
		logic sck_i;
		logic mosi_i;
		logic miso_i;
		logic ss_n_i;
	} spimsp_pins_in_s;
	typedef struct packed {
		logic sck_o;
		logic sck_oe_n;
		logic mosi_o;
		logic mosi_oe_n;
		logic miso_o;
		logic miso_oe_n;
	} spimsp_pins_out_s;
endpackage

// ### spimsp_props.sv
`timescale 1ns/10ps
`include "spimsp_cfg.svh"
module spimsp_props import spimsp_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire spimsp_pins_in_s pins_i,
	input wire spimsp_pins_out_s pins_o
);
	// ==========
	// port checks
	logic [7:0] ctl_q;
	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			ctl_q <= 8'h00;
		else if (ce && psel && penable && pwrite && paddr == `SPIMSP_OFF_CTRL)
			ctl_q <= pwdata[7:0];
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence idle_s;
		!pins_o.sck_oe_n && ctl_q[1:0] == 2'h0 && $stable(ctl_q)
			&& $stable(pins_o.sck_o);
	endsequence
	a_reset_released: assert property (
		$fell(rst) |-> pins_o.sck_oe_n && pins_o.mosi_oe_n && pins_o.miso_oe_n)
		else $error("pins driven after reset");
	a_master_drives: assert property (
		!pins_o.mosi_oe_n |-> !pins_o.sck_oe_n) else $error("mosi without sck");
	a_miso_excl: assert property (
		!pins_o.miso_oe_n |-> pins_o.mosi_oe_n) else $error("miso as master");
	a_sck_idle: assert property (
		idle_s [*3] |-> pins_o.sck_o == ctl_q[5]) else $error("sck idle level");
	a_fault_release: assert property (
		!pins_o.mosi_oe_n && !pins_i.ss_n_i && !ctl_q[3] |-> ##[1:4]
		pins_o.mosi_oe_n) else $error("fault kept master");
	a_select_disable_keeps: assert property (
		ctl_q[7:6] == 2'h3 && ctl_q[3] && !pins_o.mosi_oe_n ##1 $stable(ctl_q)
		|-> !pins_o.mosi_oe_n) else $error("select not ignored");
	a_slave_quiet: assert property (
		pins_o.mosi_oe_n && !ctl_q[3] && pins_i.ss_n_i && $past(pins_i.ss_n_i)
		&& $past(pins_i.ss_n_i, 3) |-> pins_o.miso_oe_n)
		else $error("miso while deselected");
	a_unmapped_err: assert property (
		psel && penable && pready && paddr > `SPIMSP_OFF_DATA |-> pslverr)
		else $error("no error on unmapped");
endmodule // spimsp_props
bind spimsp_top spimsp_props u_props (.clk(clk), .rst(rst), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .pslverr(pslverr), .pins_i(pins_i),
	.pins_o(pins_o));

// ### spimsp_top.sv
// Contract
// - full duplex byte shifting on serial clock
// - generated clock at most half system clock
// - mosi driven as master, input as slave
// - miso sampled as master, driven as slave
// - bit order selects msb or lsb first
// - master makes sck, slave uses external sck
// - 4-wire slave ignores bus when deselected
// - select disable ignores select input entirely
// - master with select low sets mode fault
// - data write starts master transfer
// - idle write loads shifter then shifts
// - master end fills buffer, sets flags
// - master busy from write to eighth period
// - slave starts on select low, held low
// - select disabled slave ready on enable
// - slave stores byte only if buffer empty
// - each slave byte sets done and full
// - slave busy follows select or enable
// - polarity sets idle clock level
// - phase selects sampling edge
// - rate divides system clock by 2 to 16
// - mode fault clears enable and master select
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`include "spimsp_cfg.svh"
module spimsp_top import spimsp_pkg::*; (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire spimsp_pins_in_s pins_i,
	output spimsp_pins_out_s pins_o
);
	// ==========================================================
	// declarations
	logic [7:0] ctrl_q;
	logic done_q, wcol_q, mode_fault_flag_q, ovr_q, full_q;
	logic [7:0] rxbuf_q;
	logic [7:0] shift_q;
	logic [3:0] bits_q;
	logic in_bit_q;
	logic sck_q;
	logic sck_in_q;
	logic [7:0] rd_d;
	spimsp_state_e st_q;
	logic en, mst, cpol, cpha, select_disable, lsb;
	logic acc, wr_ctrl, wr_stat, wr_data, rd_data, hit;
	logic tick, mbusy, sbusy, busy;
	logic sel_ok, slave_act;
	logic sck_lvl, s_rise, s_fall, s_lead, s_trail;
	logic m_sample, m_shift, m_end, s_end, byte_end;
	logic start;
	logic in_bit;

	assign en = ctrl_q[`SPIMSP_CTL_EN];
	assign mst = ctrl_q[`SPIMSP_CTL_MST];
	assign cpol = ctrl_q[`SPIMSP_CTL_CPOL];
	assign cpha = ctrl_q[`SPIMSP_CTL_CPHA];
	assign select_disable = ctrl_q[`SPIMSP_CTL_SELECT_DISABLE];
	assign lsb = ctrl_q[`SPIMSP_CTL_LSB];

	// ==========================================================
	// helpers
	function automatic logic out_bit(input logic [7:0] s, input logic l);
		out_bit = l ? s[0] : s[7];
	endfunction
	function automatic logic [7:0] shift_in(input logic [7:0] s,
		input logic l, input logic b);
		shift_in = l ? {b, s[7:1]} : {s[6:0], b};
	endfunction

	// ==========================================================
	// apb decode, zero wait state
	assign acc = psel && penable;
	assign hit = (paddr == `SPIMSP_OFF_CTRL) || (paddr == `SPIMSP_OFF_STAT)
		|| (paddr == `SPIMSP_OFF_DATA);
	assign wr_ctrl = ce && acc && pwrite && (paddr == `SPIMSP_OFF_CTRL);
	assign wr_stat = ce && acc && pwrite && (paddr == `SPIMSP_OFF_STAT);
	assign wr_data = ce && acc && pwrite && (paddr == `SPIMSP_OFF_DATA);
	assign rd_data = ce && acc && !pwrite && (paddr == `SPIMSP_OFF_DATA);
	assign pready = 1'b1;
	assign pslverr = acc && !hit;

	always_comb begin
		rd_d = 8'h00;
		unique case (paddr)
			`SPIMSP_OFF_CTRL: rd_d = ctrl_q;
			`SPIMSP_OFF_STAT: rd_d = {done_q, wcol_q, mode_fault_flag_q, ovr_q, full_q,
				busy, 2'b00};
			`SPIMSP_OFF_DATA: rd_d = rxbuf_q;
			default: rd_d = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prdata <= 32'h0000_0000;
		end else if (ce && psel && !penable && !pwrite) begin
			prdata <= {24'h00_0000, rd_d};
		end
	end

	// ==========================================================
	// select and busy
	assign sel_ok = select_disable || !pins_i.ss_n_i;
	assign slave_act = en && !mst && sel_ok;
	assign mbusy = (st_q != SPIMSP_IDLE);
	assign sbusy = select_disable ? en : !pins_i.ss_n_i;
	assign busy = mst ? mbusy : (!mst && sbusy);
	assign start = wr_data && mst && en && !mbusy;

	// ==========================================================
	// control register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_q <= `SPIMSP_CTRL_RST;
		end else if (ce) begin
			if (en && mst && !select_disable && !pins_i.ss_n_i) begin
				ctrl_q[`SPIMSP_CTL_EN] <= 1'b0;
				ctrl_q[`SPIMSP_CTL_MST] <= 1'b0;
			end else if (wr_ctrl) begin
				ctrl_q <= pwdata[7:0];
			end
		end
	end

	// ==========================================================
	// master clock generation
	spimsp_clkdiv u_div (
		.clk(clk),
		.rst(rst),
		.ce(ce),
		.run(mbusy),
		.rate(ctrl_q[1:0]),
		.tick(tick)
	);

	// phase set: sample miso on the second edge, together with the shift
	logic m_in;
	assign m_in = cpha ? pins_i.miso_i : in_bit_q;
	assign m_sample = tick && (st_q == SPIMSP_LEAD) && !cpha;
	assign m_shift = tick && (st_q == SPIMSP_TRAIL);
	assign m_end = m_shift && (bits_q == `SPIMSP_BITS - 4'h1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_q <= SPIMSP_IDLE;
		end else if (ce) begin
			if (!mst || !en) begin
				st_q <= SPIMSP_IDLE;
			end else begin
				unique case (st_q)
					SPIMSP_IDLE: if (start) st_q <= SPIMSP_LEAD;
					SPIMSP_LEAD: if (tick) st_q <= SPIMSP_TRAIL;
					SPIMSP_TRAIL: if (tick) st_q <= m_end ? SPIMSP_IDLE
						: SPIMSP_LEAD;
					default: st_q <= SPIMSP_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_q <= 1'b0;
		end else if (ce) begin
			if (st_q == SPIMSP_IDLE) begin
				sck_q <= cpol;
			end else if (tick) begin
				sck_q <= !sck_q;
			end
		end
	end

	// ==========================================================
	// slave clock edges
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sck_in_q <= 1'b0;
		end else if (ce) begin
			sck_in_q <= pins_i.sck_i;
		end
	end
	assign sck_lvl = pins_i.sck_i;
	assign s_rise = slave_act && sck_lvl && !sck_in_q;
	assign s_fall = slave_act && !sck_lvl && sck_in_q;
	assign s_lead = cpol ? s_fall : s_rise;
	assign s_trail = cpol ? s_rise : s_fall;

	// ==========================================================
	// shift engine, sample on first edge unless phase set
	logic do_sample, do_shift;
	assign do_sample = mst ? m_sample : (cpha ? s_trail : s_lead);
	assign do_shift = mst ? m_shift : (cpha ? s_lead : s_trail);
	assign in_bit = mst ? pins_i.miso_i : pins_i.mosi_i;
	assign s_end = !mst && do_sample && (bits_q == `SPIMSP_BITS - 4'h1);
	assign byte_end = m_end || s_end;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			shift_q <= 8'h00;
			bits_q <= 4'h0;
			in_bit_q <= 1'b0;
		end else if (ce) begin
			if (start) begin
				shift_q <= pwdata[7:0];
				bits_q <= 4'h0;
			end else if (!mst && !slave_act) begin
				bits_q <= 4'h0;
				if (wr_data && !sbusy) begin
					shift_q <= pwdata[7:0];
				end
			end else begin
				if (do_sample) begin
					in_bit_q <= in_bit;
					if (!mst) begin
						shift_q <= shift_in(shift_q, lsb, in_bit);
						bits_q <= s_end ? 4'h0 : bits_q + 4'h1;
					end
				end
				if (do_shift && mst) begin
					shift_q <= shift_in(shift_q, lsb, m_in);
					bits_q <= bits_q + 4'h1;
				end
			end
		end
	end

	// ==========================================================
	// receive buffer and status flags, set wins over clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rxbuf_q <= 8'h00;
			done_q <= 1'b0;
			wcol_q <= 1'b0;
			mode_fault_flag_q <= 1'b0;
			ovr_q <= 1'b0;
			full_q <= 1'b0;
		end else if (ce) begin
			if (wr_stat && !pwdata[`SPIMSP_ST_DONE]) done_q <= 1'b0;
			if (wr_stat && !pwdata[`SPIMSP_ST_WCOL]) wcol_q <= 1'b0;
			if (wr_stat && !pwdata[`SPIMSP_ST_MODE_FAULT_FLAG]) mode_fault_flag_q <= 1'b0;
			if ((wr_stat && !pwdata[`SPIMSP_ST_OVR]) || rd_data) ovr_q <= 1'b0;
			if ((wr_stat && !pwdata[`SPIMSP_ST_FULL]) || rd_data) full_q <= 1'b0;
			if (wr_data && !start && busy) wcol_q <= 1'b1;
			if (wr_data && start) wcol_q <= 1'b0;
			if (en && mst && !select_disable && !pins_i.ss_n_i) mode_fault_flag_q <= 1'b1;
			if (m_end) begin
				rxbuf_q <= shift_in(shift_q, lsb, m_in);
				done_q <= 1'b1;
				full_q <= 1'b1;
			end
			if (s_end) begin
				done_q <= 1'b1;
				full_q <= 1'b1;
				if (!full_q) begin
					rxbuf_q <= shift_in(shift_q, lsb, in_bit);
				end else begin
					ovr_q <= 1'b1;
				end
			end
		end
	end

	// ==========================================================
	// pin drive, enables low while driving
	always_comb begin
		pins_o.sck_o = sck_q;
		pins_o.sck_oe_n = !(en && mst);
		pins_o.mosi_o = out_bit(shift_q, lsb);
		pins_o.mosi_oe_n = !(en && mst);
		pins_o.miso_o = out_bit(shift_q, lsb);
		pins_o.miso_oe_n = !slave_act;
	end
endmodule // spimsp_top

// ### test_spi_master_slave_port.sv
`timescale 1ns/10ps
module test_spi_master_slave_port import spimsp_pkg::*;;
	// ==========
	// bench
	logic clk, rst, ce, psel, penable, pwrite, pslverr, pready, e;
	logic tsck, tmosi, ss_n, msel_n, mmiso;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] mtx, mrx, g;
	spimsp_pins_in_s pi;
	spimsp_pins_out_s po;
	int num_errors = 0, n_tests = 0;
	time t0, t1;
	wire w_sck = po.sck_oe_n ? tsck : po.sck_o;
	wire w_mosi = po.mosi_oe_n ? tmosi : po.mosi_o;
	wire w_miso = po.miso_oe_n ? mmiso : po.miso_o;
	assign pi = {w_sck, w_mosi, w_miso, ss_n};
	spimsp_top dut (.clk(clk), .rst(rst), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pins_i(pi),
		.pins_o(po));
	spimsp_far_slave far (.sck(w_sck), .mosi(w_mosi), .sel_n(msel_n),
		.tx(mtx), .miso(mmiso), .rx(mrx));
	always @(posedge w_sck) begin
		t1 = t0;
		t0 = $time;
	end
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#80000;
		num_errors++;
		final_report();
	end
	function automatic logic [7:0] rev(input logic [7:0] v);
		for (int i = 0; i < 8; i++)
			rev[i] = v[7 - i];
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, x);
		n_tests++;
		if (s !== x) begin
			num_errors++;
			$display("wrong value %s exp %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] m, x);
		apb(1'b0, a, 32'h0);
		chk($sformatf("reg %h", a), r & m, x);
	endtask
	// external sck at a fifth of the system clock
	task automatic xfer(input logic [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk) tmosi <= d[i];
			repeat (2) @(posedge clk);
			g[i] = w_miso;
			tsck <= 1'b1;
			repeat (2) @(posedge clk);
			tsck <= 1'b0;
		end
	endtask
	task final_report;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		{rst, ce, psel, penable, pwrite, tsck, tmosi, ss_n, msel_n} = 9'h183;
		{paddr, pwdata, mtx} = '0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rd(12'h0, 32'hFF, 32'h0);
		rd(12'h4, 32'hFF, 32'h0);
		apb(1'b0, 12'hC, 32'h0);
		chk("unmapped error", {31'h0, e}, 32'h1);
		$display("test reset done");
		ss_n <= 1'b0;
		for (int k = 0; k < 4; k++) begin
			apb(1'b1, 12'h0, 32'hC8 | k | (k[0] ? 32'h4 : 32'h0));
			mtx = 8'h1E;
			msel_n = 1'b0;
			apb(1'b1, 12'h8, 32'h31);
			rd(12'h4, 32'h4, 32'h4);
			do apb(1'b0, 12'h4, 32'h0); while (r[2] === 1'b1);
			msel_n = 1'b1;
			rd(12'h4, 32'hFC, 32'h88);
			chk("far rx", mrx, k[0] ? rev(8'h31) : 8'h31);
			rd(12'h8, 32'hFF, k[0] ? rev(8'h1E) : 8'h1E);
			rd(12'h4, 32'h8, 32'h0);
			chk("sck period", 32'(t0 - t1), 32'h8 << k);
			apb(1'b1, 12'h4, 32'h0);
		end
		msel_n = 1'b0;
		apb(1'b1, 12'h8, 32'h31);
		apb(1'b1, 12'h8, 32'h77);
		do apb(1'b0, 12'h4, 32'h0); while (r[2] === 1'b1);
		msel_n = 1'b1;
		rd(12'h4, 32'h40, 32'h40);
		chk("far rx", mrx, rev(8'h31));
		apb(1'b1, 12'h0, 32'hD8);
		mtx = 8'h1E;
		msel_n = 1'b0;
		apb(1'b1, 12'h8, 32'h31);
		do apb(1'b0, 12'h4, 32'h0); while (r[2] === 1'b1);
		msel_n = 1'b1;
		chk("far rx phase", mrx, 8'h31);
		rd(12'h8, 32'hFF, 32'h1E);
		apb(1'b1, 12'h4, 32'h0);
		$display("test master done");
		apb(1'b1, 12'h0, 32'hC0);
		rd(12'h4, 32'h20, 32'h20);
		rd(12'h0, 32'hC0, 32'h0);
		apb(1'b1, 12'h4, 32'h0);
		ss_n <= 1'b1;
		$display("test fault done");
		apb(1'b1, 12'h0, 32'h80);
		apb(1'b1, 12'h8, 32'h3C);
		xfer(8'h55);
		rd(12'h4, 32'h88, 32'h0);
		ss_n <= 1'b0;
		repeat (4) @(posedge clk);
		xfer(8'h96);
		chk("slave miso", g, 8'h3C);
		rd(12'h4, 32'h8C, 32'h8C);
		xfer(8'h69);
		ss_n <= 1'b1;
		repeat (3) @(posedge clk);
		rd(12'h4, 32'h1C, 32'h18);
		rd(12'h8, 32'hFF, 32'h96);
		rd(12'h4, 32'h18, 32'h0);
		apb(1'b1, 12'h0, 32'h88);
		apb(1'b1, 12'h4, 32'h0);
		xfer(8'hC3);
		rd(12'h8, 32'hFF, 32'hC3);
		rd(12'h4, 32'h4, 32'h4);
		$display("test slave done");
		final_report();
	end
endmodule // test_spi_master_slave_port
